// File: pkg/aopm_defines.vh
// Constants shared by the analogue output parameter monitor
`ifndef AOPM_DEFINES_VH
`define AOPM_DEFINES_VH

// ****************************************
// Sizes
// ****************************************
`define AOPM_NCH 2
`define AOPM_IRQ_W 5
`define AOPM_DEC_W 17

// ****************************************
// Register map (byte addresses)
// ****************************************
`define AOPM_A_UNIT 8'h00
`define AOPM_A_STAT 8'h04
`define AOPM_A_IRQ 8'h08
`define AOPM_A_ICLR 8'h0C
`define AOPM_A_IEN 8'h10
`define AOPM_CH_PAGE 3'h1
`define AOPM_SV_PAGE 5'h08
`define AOPM_DV_PAGE 5'h09
`define AOPM_R_CFG 2'h0
`define AOPM_R_UP 2'h1
`define AOPM_R_LO 2'h2
`define AOPM_R_FLT 2'h3

// ****************************************
// Fields
// ****************************************
`define AOPM_B_SCEN 0
`define AOPM_F_FMT 2:1
`define AOPM_FMT_OFFSET 2'h0
`define AOPM_FMT_SCALED 2'h3
`define AOPM_F_RNG 2:0
`define AOPM_B_UPEN 3
`define AOPM_B_LOEN 4
`define AOPM_B_FLT 5
`define AOPM_B_IDLE 6
`define AOPM_B_SIGN 15
`define AOPM_F_MAG 14:0

// ****************************************
// Reset values and responses
// ****************************************
`define AOPM_RST_CFG 7'h40
`define AOPM_RST_UP 16'h03E8
`define AOPM_RST_LO 16'h0000
`define AOPM_RST_FLT 16'h0000
`define AOPM_RST_UNIT 3'h0
`define AOPM_RESP_OK 2'h0
`define AOPM_RESP_ERR 2'h2

`endif

// File: verilog/aopm_chan.v
// One output channel: set value decode, output selection, limit checks
`timescale 1ns/1ps
`default_nettype none
`include "aopm_defines.vh"

module aopm_chan (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Parameters
  input wire [15:0] set_val,
  input wire [15:0] up_lim,
  input wire [15:0] lo_lim,
  input wire [15:0] flt_val,
  input wire up_en,
  input wire lo_en,
  input wire flt_en,
  input wire idle_en,
  // Link state
  input wire comm_err,
  input wire comm_idle,
  // Results
  output reg [15:0] out_q,
  output reg [`AOPM_DEC_W-1:0] dec_q,
  output reg up_err_q,
  output reg lo_err_q
);

  // Sign-magnitude hundredths to two's complement
  function [`AOPM_DEC_W-1:0] sm_dec;
    input [15:0] v;
    reg [`AOPM_DEC_W-1:0] m;
    begin
      m = {2'b00, v[`AOPM_F_MAG]};
      sm_dec = v[`AOPM_B_SIGN] ? (~m + 1'b1) : m;
    end
  endfunction

  reg [15:0] out_d;
  wire signed [`AOPM_DEC_W-1:0] val_s;
  wire signed [`AOPM_DEC_W-1:0] up_s;
  wire signed [`AOPM_DEC_W-1:0] lo_s;

  assign val_s = sm_dec(out_q);
  assign up_s = sm_dec(up_lim);
  assign lo_s = sm_dec(lo_lim);

  // Fault has priority over idle: a broken link is never idle
  always @* begin
    out_d = set_val;
    if (comm_err) begin
      out_d = flt_en ? flt_val : out_q;
    end else if (comm_idle && idle_en) begin
      out_d = lo_lim;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= `AOPM_RST_LO;
      dec_q <= {`AOPM_DEC_W{1'b0}};
      up_err_q <= 1'b0;
      lo_err_q <= 1'b0;
    end else begin
      out_q <= out_d;
      dec_q <= sm_dec(set_val);
      up_err_q <= up_en && (val_s > up_s);
      lo_err_q <= lo_en && (val_s < lo_s);
    end
  end

endmodule
`default_nettype wire

// File: verilog/aopm_top.v
// Analogue output parameter monitor with AXI4-Lite register access
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "aopm_defines.vh"

module aopm_top (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Handheld terminal write port
  input wire term_we,
  input wire [7:0] term_addr,
  input wire [15:0] term_wdata,
  // Link and supply state
  input wire comm_err,
  input wire comm_idle,
  input wire supply_short,
  // Outputs
  output wire [16*`AOPM_NCH-1:0] ch_out_q,
  output reg short_err_q,
  output reg irq_q
);

  // ****************************************
  // Bus handshake
  // ****************************************
  wire wr_hs;
  wire rd_hs;
  wire [15:0] wmask;
  wire [15:0] hwdata;
  reg wr_ok;

  assign wr_hs = s_axi_awvalid && s_axi_awready;
  assign rd_hs = s_axi_arvalid && s_axi_arready;
  assign wmask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign hwdata = s_axi_wdata[15:0];

  // Address and data are taken together, one write in flight at a time
  // Ready pulses last one cycle; the response waits for bready
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AOPM_RESP_OK;
    end else begin
      s_axi_awready <= !s_axi_awready && s_axi_awvalid &&
                       s_axi_wvalid && !s_axi_bvalid;
      s_axi_wready <= !s_axi_awready && s_axi_awvalid &&
                      s_axi_wvalid && !s_axi_bvalid;
      if (wr_hs) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `AOPM_RESP_OK : `AOPM_RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Write decode
  // ****************************************
  wire hw_unit;
  wire hw_iclr;
  wire hw_ien;
  wire tw_unit;
  wire tw_ien;

  assign hw_unit = wr_hs && (s_axi_awaddr == `AOPM_A_UNIT);
  assign hw_iclr = wr_hs && (s_axi_awaddr == `AOPM_A_ICLR);
  assign hw_ien = wr_hs && (s_axi_awaddr == `AOPM_A_IEN);
  assign tw_unit = term_we && (term_addr == `AOPM_A_UNIT);
  assign tw_ien = term_we && (term_addr == `AOPM_A_IEN);

  // Unmapped writes still complete, with an error and no effect
  always @* begin
    wr_ok = 1'b0;
    case (s_axi_awaddr)
      `AOPM_A_UNIT, `AOPM_A_ICLR, `AOPM_A_IEN: wr_ok = 1'b1;
      default: begin
        wr_ok = (s_axi_awaddr[7:5] == `AOPM_CH_PAGE) ||
                (s_axi_awaddr[7:3] == `AOPM_SV_PAGE);
      end
    endcase
  end

  // ****************************************
  // Unit settings
  // ****************************************
  reg [2:0] unit_q;
  reg [`AOPM_IRQ_W-1:0] ien_q;

  // Terminal write lands after the host's in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      unit_q <= `AOPM_RST_UNIT;
      ien_q <= {`AOPM_IRQ_W{1'b0}};
    end else begin
      if (hw_unit && s_axi_wstrb[0]) begin
        unit_q <= hwdata[2:0];
      end
      if (tw_unit) begin
        unit_q <= term_wdata[2:0];
      end
      if (hw_ien && s_axi_wstrb[0]) begin
        ien_q <= hwdata[`AOPM_IRQ_W-1:0];
      end
      if (tw_ien) begin
        ien_q <= term_wdata[`AOPM_IRQ_W-1:0];
      end
    end
  end

  // ****************************************
  // Per-channel settings and datapath
  // ****************************************
  reg [6:0] cfg_q [0:`AOPM_NCH-1];
  reg [15:0] up_q [0:`AOPM_NCH-1];
  reg [15:0] lo_q [0:`AOPM_NCH-1];
  reg [15:0] flt_q [0:`AOPM_NCH-1];
  reg [15:0] set_q [0:`AOPM_NCH-1];
  wire [`AOPM_DEC_W-1:0] dec_w [0:`AOPM_NCH-1];
  wire [`AOPM_NCH-1:0] up_err;
  wire [`AOPM_NCH-1:0] lo_err;

  // Format is stored only: limit checks always decode sign-magnitude
  // Range changes leave the limits alone; the configurer rechecks them
  genvar gi;
  generate
    for (gi = 0; gi < `AOPM_NCH; gi = gi + 1) begin : g_ch
      wire hsel;
      wire tsel;
      wire hsv;
      wire [1:0] hreg;
      wire [1:0] treg;
      wire [15:0] hcfg;

      assign hsel = wr_hs && (s_axi_awaddr[7:5] == `AOPM_CH_PAGE) &&
                    (s_axi_awaddr[4] == gi);
      assign tsel = term_we && (term_addr[7:5] == `AOPM_CH_PAGE) &&
                    (term_addr[4] == gi);
      assign hsv = wr_hs && (s_axi_awaddr[7:3] == `AOPM_SV_PAGE) &&
                   (s_axi_awaddr[2] == gi);
      assign hreg = s_axi_awaddr[3:2];
      assign treg = term_addr[3:2];
      assign hcfg = (hwdata & wmask) | ({9'h000, cfg_q[gi]} & ~wmask);

      always @(posedge aclk) begin
        if (!aresetn) begin
          cfg_q[gi] <= `AOPM_RST_CFG;
          up_q[gi] <= `AOPM_RST_UP;
          lo_q[gi] <= `AOPM_RST_LO;
          flt_q[gi] <= `AOPM_RST_FLT;
          set_q[gi] <= `AOPM_RST_LO;
        end else begin
          if (hsel && hreg == `AOPM_R_CFG) begin
            // Host may not touch the idle behaviour bit
            cfg_q[gi] <= {cfg_q[gi][`AOPM_B_IDLE], hcfg[5:0]};
          end
          if (hsel && hreg == `AOPM_R_UP) begin
            up_q[gi] <= (hwdata & wmask) | (up_q[gi] & ~wmask);
          end
          if (hsel && hreg == `AOPM_R_LO) begin
            lo_q[gi] <= (hwdata & wmask) | (lo_q[gi] & ~wmask);
          end
          if (hsel && hreg == `AOPM_R_FLT) begin
            flt_q[gi] <= (hwdata & wmask) | (flt_q[gi] & ~wmask);
          end
          if (hsv) begin
            set_q[gi] <= (hwdata & wmask) | (set_q[gi] & ~wmask);
          end
          // Terminal writes come last so they win a same-cycle collision
          if (tsel && treg == `AOPM_R_CFG) begin
            cfg_q[gi] <= term_wdata[6:0];
          end
          if (tsel && treg == `AOPM_R_UP) begin
            up_q[gi] <= term_wdata;
          end
          if (tsel && treg == `AOPM_R_LO) begin
            lo_q[gi] <= term_wdata;
          end
          if (tsel && treg == `AOPM_R_FLT) begin
            flt_q[gi] <= term_wdata;
          end
        end
      end

      aopm_chan u_chan (
        .aclk(aclk),
        .aresetn(aresetn),
        .set_val(set_q[gi]),
        .up_lim(up_q[gi]),
        .lo_lim(lo_q[gi]),
        .flt_val(flt_q[gi]),
        .up_en(cfg_q[gi][`AOPM_B_UPEN]),
        .lo_en(cfg_q[gi][`AOPM_B_LOEN]),
        .flt_en(cfg_q[gi][`AOPM_B_FLT]),
        .idle_en(cfg_q[gi][`AOPM_B_IDLE]),
        .comm_err(comm_err),
        .comm_idle(comm_idle),
        .out_q(ch_out_q[16*gi+15:16*gi]),
        .dec_q(dec_w[gi]),
        .up_err_q(up_err[gi]),
        .lo_err_q(lo_err[gi])
      );
    end
  endgenerate

  // ****************************************
  // Short monitor and interrupts
  // ****************************************
  wire [`AOPM_IRQ_W-1:0] cond;
  reg [`AOPM_IRQ_W-1:0] cond_q;
  reg [`AOPM_IRQ_W-1:0] ist_q;
  wire [`AOPM_IRQ_W-1:0] rise;
  wire [`AOPM_IRQ_W-1:0] clr;

  assign cond = {lo_err, up_err, short_err_q};
  // Edge detect: a flag that stays up raises one interrupt, not many
  assign rise = cond & ~cond_q;
  // A zero bit in a clear write leaves that status bit alone
  assign clr = hw_iclr ? s_axi_wdata[`AOPM_IRQ_W-1:0] :
               {`AOPM_IRQ_W{1'b0}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      short_err_q <= 1'b0;
      cond_q <= {`AOPM_IRQ_W{1'b0}};
      ist_q <= {`AOPM_IRQ_W{1'b0}};
      irq_q <= 1'b0;
    end else begin
      // Level flag: drops as soon as the short or the enable goes
      short_err_q <= unit_q[`AOPM_B_SCEN] && supply_short;
      cond_q <= cond;
      // A new event beats a clear in the same cycle
      ist_q <= (ist_q & ~clr) | rise;
      // Built from the next status so both change on one edge
      irq_q <= |(((ist_q & ~clr) | rise) & ien_q);
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  reg [31:0] rd_d;
  reg rd_ok;
  integer ci;

  // Unmapped reads return zero data with an error response
  always @* begin
    rd_d = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `AOPM_A_UNIT: rd_d = {29'h0, unit_q};
      `AOPM_A_STAT: rd_d = {25'h0, comm_idle, comm_err, cond};
      `AOPM_A_IRQ: rd_d = {27'h0, ist_q};
      `AOPM_A_ICLR: rd_d = 32'h0000_0000;
      `AOPM_A_IEN: rd_d = {27'h0, ien_q};
      default: begin
        rd_ok = 1'b0;
        for (ci = 0; ci < `AOPM_NCH; ci = ci + 1) begin
          if (s_axi_araddr[7:5] == `AOPM_CH_PAGE &&
              s_axi_araddr[4] == ci[0]) begin
            rd_ok = 1'b1;
            case (s_axi_araddr[3:2])
              `AOPM_R_CFG: rd_d = {25'h0, cfg_q[ci]};
              `AOPM_R_UP: rd_d = {16'h0, up_q[ci]};
              `AOPM_R_LO: rd_d = {16'h0, lo_q[ci]};
              default: rd_d = {16'h0, flt_q[ci]};
            endcase
          end
          if (s_axi_araddr[7:3] == `AOPM_SV_PAGE &&
              s_axi_araddr[2] == ci[0]) begin
            rd_ok = 1'b1;
            rd_d = {16'h0, set_q[ci]};
          end
          if (s_axi_araddr[7:3] == `AOPM_DV_PAGE &&
              s_axi_araddr[2] == ci[0]) begin
            rd_ok = 1'b1;
            // Decoded value, sign extended to the full word
            rd_d = {{15{dec_w[ci][`AOPM_DEC_W-1]}}, dec_w[ci]};
          end
        end
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `AOPM_RESP_OK;
    end else begin
      // One read in flight: no new address while the data waits
      s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
      if (rd_hs) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= rd_ok ? `AOPM_RESP_OK : `AOPM_RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// File: tb/aopm_top_monitor.sv
// Port-level assertions for the analogue output parameter monitor
`timescale 1ns/1ps
`default_nettype none
`include "aopm_defines.vh"
module aopm_top_monitor (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Host and terminal writes
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire term_we,
  input wire [7:0] term_addr,
  input wire [15:0] term_wdata,
  // Link state and results
  input wire comm_err,
  input wire comm_idle,
  input wire supply_short,
  input wire [16*`AOPM_NCH-1:0] ch_out_q,
  input wire short_err_q,
  input wire irq_q
);
  // ****************************************
  // Register shadow
  // ****************************************
  // Tracks writes so that channel 0 output can be predicted
  logic [15:0] sh_q [64];
  wire [15:0] cfg0 = sh_q[8];
  wire [15:0] lo0 = sh_q[10];
  wire [15:0] flt0 = sh_q[11];
  wire [15:0] sv0 = sh_q[16];
  wire [4:0] ien = sh_q[4][4:0];
  wire unit_en = sh_q[0][0];
  wire [15:0] ch0 = ch_out_q[15:0];
  wire keep6 = (s_axi_awaddr == 8'h20) ? cfg0[6] : s_axi_wdata[6];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 64; i++) begin
        sh_q[i] <= 16'h0000;
      end
      sh_q[8] <= 16'h0040;
      sh_q[9] <= 16'h03E8;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        sh_q[s_axi_awaddr[7:2]] <=
          {s_axi_wdata[15:7], keep6, s_axi_wdata[5:0]};
      end
      // Terminal last: it wins a same-cycle collision
      if (term_we) begin
        sh_q[term_addr[7:2]] <= term_wdata;
      end
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_SHORT_RAISE: assert property (
    $past(supply_short && unit_en) |-> short_err_q)
    else $error("short error not raised");
  AST_SHORT_QUIET: assert property (
    !$past(unit_en) |-> !short_err_q)
    else $error("short error while monitor off");
  AST_SHORT_CLEAR: assert property (
    $fell(supply_short) |=> !short_err_q)
    else $error("short error did not clear");
  AST_FAULT_HOLD: assert property (
    $past(comm_err) && !$past(cfg0[5]) |-> $stable(ch0))
    else $error("output not held on link fault");
  AST_FAULT_VALUE: assert property (
    $past(comm_err) && $past(cfg0[5]) |-> ch0 == $past(flt0))
    else $error("fault value not driven");
  AST_IDLE_LOW: assert property (
    $past(!comm_err && comm_idle && cfg0[6]) |-> ch0 == $past(lo0))
    else $error("idle output not lower limit");
  AST_NORMAL_OUT: assert property (
    $past(!comm_err && !(comm_idle && cfg0[6])) |-> ch0 == $past(sv0))
    else $error("output not set value");
  AST_IRQ_GATE: assert property (
    ien == 5'h00 && $past(ien) == 5'h00 |-> !irq_q)
    else $error("interrupt with all sources masked");
endmodule
bind aopm_top aopm_top_monitor i_aopm_top_monitor (.*);
`default_nettype wire

// File: tb/aopm_host.sv
// Fieldbus host model: AXI4-Lite master for the parameter registers
`timescale 1ns/1ps
`default_nettype none
module aopm_host (
  // Clock
  input wire logic aclk,
  // Write channels
  output var logic [7:0] s_axi_awaddr,
  output var logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output var logic [31:0] s_axi_wdata,
  output var logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output var logic s_axi_bready,
  // Read channels
  output var logic [7:0] s_axi_araddr,
  output var logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output var logic s_axi_rready
);
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // Response accept is delayed at random to act as a slow host
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_aopm_top.sv
// Self-checking bench for the analogue output parameter monitor
`timescale 1ns/1ps
`default_nettype none
module tb_aopm_top;
  logic aclk, aresetn, term_we, comm_err, comm_idle, supply_short;
  logic [7:0] term_addr;
  logic [15:0] term_wdata, v;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata, ch_out_q;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  wire s_axi_rvalid, s_axi_rready, short_err_q, irq_q;
  int n_mismatch, check_count;
  logic [1:0] r;
  logic [31:0] d;
  logic [15:0] tbl [5] = '{16'h041A, 16'h841A, 16'h8000, 16'hFFFF, 16'h7FFF};
  logic [31:0] sv_t [5] = '{32'h41A, 32'h3E8, 32'h64, 32'h841A, 32'h1F4};
  logic [31:0] st_t [5] = '{32'h2, 32'h0, 32'h0, 32'h8, 32'h0};
  aopm_host i_aopm_host (.*);
  aopm_top i_aopm_top (.*, .s_axi_wstrb(4'h3));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // About 350 cycles of tests; the 20000-cycle limit leaves wide margin
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] x);
    i_aopm_host.wr(a, x, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    i_aopm_host.rd(a, d, r);
    chk(d, e);
  endtask
  task automatic tw(input logic [7:0] a, input logic [15:0] x);
    term_addr <= a;
    term_wdata <= x;
    term_we <= 1'b1;
    @(posedge aclk);
    term_we <= 1'b0;
  endtask
  function automatic logic [31:0] dec(input logic [15:0] x);
    dec = x[15] ? -{17'h0, x[14:0]} : {17'h0, x[14:0]};
  endfunction
  initial begin
    {aresetn, term_we, comm_err, comm_idle, supply_short} = 5'h00;
    term_addr = 8'h00;
    term_wdata = 16'h0000;
    void'($urandom(32'h9634));
    cy(4);
    aresetn <= 1'b1;
    cy(1);
    rc(8'h00, 32'h0);
    rc(8'h20, 32'h40);
    rc(8'h24, 32'h3E8);
    rc(8'h38, 32'h0);
    rc(8'h3C, 32'h0);
    w(8'hFC, 32'h1);
    chk(r, 32'h2);
    rc(8'hFC, 32'h0);
    chk(r, 32'h2);
    for (int i = 0; i < 5; i++) begin
      w(8'h30, 32'(i));
      rc(8'h30, 32'h40 | 32'(i));
      w(8'h00, 32'(i) << 1);
      rc(8'h00, 32'(i & 3) << 1);
    end
    w(8'h34, 32'h834);
    w(8'h38, 32'h12C);
    rc(8'h38, 32'h12C);
    w(8'h44, 32'h0834);
    chk(r, 32'h0);
    cy(1);
    chk(ch_out_q[31:16], 16'h0834);
    rc(8'h4C, 32'h834);
    for (int i = 0; i < 12; i++) begin
      v = (i < 5) ? tbl[i % 5] : 16'($urandom);
      w(8'h40, {16'h0, v});
      rc(8'h48, dec(v));
      chk(ch_out_q[15:0], v);
    end
    // Limit window with boundaries on both sides
    w(8'h28, 32'h64);
    w(8'h20, 32'h18);
    w(8'h10, 32'h1F);
    for (int i = 0; i < 5; i++) begin
      w(8'h40, sv_t[i]);
      cy(4);
      rc(8'h04, st_t[i]);
    end
    chk(irq_q, 1'b1);
    rc(8'h08, 32'hA);
    w(8'h0C, 32'h1F);
    cy(2);
    rc(8'h08, 32'h0);
    chk(irq_q, 1'b0);
    w(8'h00, 32'h1);
    supply_short <= 1'b1;
    cy(3);
    chk(short_err_q, 1'b1);
    rc(8'h04, 32'h1);
    supply_short <= 1'b0;
    cy(3);
    chk(short_err_q, 1'b0);
    chk(irq_q, 1'b1);
    w(8'h10, 32'h0);
    cy(2);
    chk(irq_q, 1'b0);
    w(8'h00, 32'h0);
    supply_short <= 1'b1;
    cy(3);
    chk(short_err_q, 1'b0);
    supply_short <= 1'b0;
    w(8'h2C, 32'h309);
    w(8'h20, 32'h20);
    comm_err <= 1'b1;
    cy(3);
    chk(ch_out_q[15:0], 16'h0309);
    chk(ch_out_q[31:16], 16'h0834);
    comm_err <= 1'b0;
    w(8'h20, 32'h0);
    comm_err <= 1'b1;
    w(8'h40, 32'h123);
    cy(3);
    chk(ch_out_q[15:0], 16'h01F4);
    comm_err <= 1'b0;
    comm_idle <= 1'b1;
    cy(3);
    chk(ch_out_q[15:0], 16'h0064);
    chk(ch_out_q[31:16], 16'h012C);
    tw(8'h20, 16'h0000);
    cy(3);
    chk(ch_out_q[15:0], 16'h0123);
    w(8'h20, 32'h40);
    rc(8'h20, 32'h0);
    tw(8'h2C, 16'h8005);
    rc(8'h2C, 32'h8005);
    tw(8'h00, 16'h0006);
    rc(8'h00, 32'h6);
    tw(8'h24, 16'h07D0);
    rc(8'h24, 32'h7D0);
    comm_idle <= 1'b0;
    final_report();
  end
endmodule
`default_nettype wire
